// ===== hw/daq_trigger_routing_dac_dma_config.sv
// configuration bank: trigger routing, analog output setup and dma select
`timescale 1ns/1ns
// Operation
// - bus-trigger select set: start only from trigger bus, ignore local
// - select clear: start on start-register write or external pin fall
// - second command register sits at offset 0x02, 16-bit, write-only
// - bits 15..8 of second register clear at power-up and reset
// - bits 7..0 undefined after power-up, untouched by reset
// - bit 15 picks timer trigger from line A4 or connector
// - delayed update mode loads output converters on timer trigger low
// - bit 14 drives line A4 with counter 5 output, else releases
// - bit 13 feeds counter gate 1 from line A2, not connector
// - bit 12 drives line A2 with counter 2 output, else releases
// - bit 11 makes converter 1 bipolar two's complement, else unipolar
// - bit 10 makes converter 0 bipolar two's complement, else unipolar
// - bit 9 gives converter 1 external reference, else internal
// - bit 8 gives converter 0 external reference, else internal
// - bits 5..3 select the secondary dma channel
// - bits 2..0 select the primary dma channel
// - acquisition enable clear ignores every acquisition trigger
module daq_trigger_routing_dac_dma_config (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [daq_cfg_pkg::addr_w-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_acq_trigger_n_i,
    input wire logic connector_timer_trigger_n_i,
    input wire logic connector_counter1_gate_i,
    input wire logic line4_i,
    input wire logic line2_i,
    input wire logic bus_start_trigger_n_i,
    input wire logic counter5_output_i,
    input wire logic counter2_output_i,
    input wire logic delayed_update_i,
    output logic line4_o,
    output logic line4_oe_o,
    output logic line2_o,
    output logic line2_oe_o,
    output logic counter1_gate_o,
    output logic timer_trigger_n_o,
    output logic dac_update_o,
    output logic acq_start_o,
    output daq_cfg_pkg::analog_cfg_t analog_cfg_o,
    output daq_cfg_pkg::dma_cfg_t dma_cfg_o
);
    import daq_cfg_pkg::*;

    logic acquisition_enable;
    logic bus_trigger_select;
    logic [7:0] cmd2_upper;
    logic [7:0] cmd2_lower;
    logic access;
    logic wr_take;
    logic wr_cmd1;
    logic wr_cmd2;
    logic wr_start;
    logic ext_fall;
    logic bus_fall;
    logic line4_s;
    logic line2_s;
    logic conn_tmr_s;
    logic conn_gate_s;
    logic next_timer_trigger_n;
    logic next_start;
    logic [7:0] pri_en;
    logic [7:0] sec_en;

    // single-cycle ack; the master drops the request one cycle later
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a write lands on the edge that samples ack, while data is still held
    assign wr_take = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    always_comb begin
        wr_cmd1 = 1'b0;
        wr_cmd2 = 1'b0;
        wr_start = 1'b0;
        if (wr_take && wb_adr_i == cmd1_addr) begin
            wr_cmd1 = 1'b1;
        end else if (wr_take && wb_adr_i == cmd2_addr) begin
            wr_cmd2 = 1'b1;
        end else if (wr_take && wb_adr_i == start_addr) begin
            wr_start = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= access;
        end
    end

    // every register is write-only, so reads and unmapped hits return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= 32'h0;
        end
    end

    // first register: only the enable and trigger-select bits live here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {acquisition_enable, bus_trigger_select} <= cmd1_reset;
        end else if (wr_cmd1) begin
            if (wb_sel_i[1]) begin
                acquisition_enable <= wb_dat_i[acq_enable_bit];
            end
            if (wb_sel_i[0]) begin
                // reserved bits 3..0 are dropped
                bus_trigger_select <= wb_dat_i[bus_trigger_select_bit];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd2_upper <= cmd2_upper_reset;
        end else if (wr_cmd2 && wb_sel_i[1]) begin
            cmd2_upper <= wb_dat_i[15:8];
        end
    end

    // lower byte keeps its content through reset
    always_ff @(posedge clk_i) begin
        if (wr_cmd2 && wb_sel_i[0]) begin
            cmd2_lower <= wb_dat_i[7:0];
        end
    end

    sync_fall_detect u_ext (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(external_acq_trigger_n_i),
        .level_o(),
        .fall_o(ext_fall)
    );

    sync_fall_detect u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(bus_start_trigger_n_i),
        .level_o(),
        .fall_o(bus_fall)
    );

    sync_fall_detect u_line4 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(line4_i),
        .level_o(line4_s),
        .fall_o()
    );

    sync_fall_detect u_line2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(line2_i),
        .level_o(line2_s),
        .fall_o()
    );

    sync_fall_detect u_conn_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(connector_timer_trigger_n_i),
        .level_o(conn_tmr_s),
        .fall_o()
    );

    sync_fall_detect u_conn_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(connector_counter1_gate_i),
        .level_o(conn_gate_s),
        .fall_o()
    );

    always_comb begin
        next_start = 1'b0;
        if (!acquisition_enable) begin
            next_start = 1'b0;
        end else if (bus_trigger_select) begin
            next_start = bus_fall;
        end else begin
            next_start = wr_start || ext_fall;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acq_start_o <= 1'b0;
        end else begin
            acq_start_o <= next_start;
        end
    end

    assign next_timer_trigger_n = cmd2_upper[line4_receive_bit-8] ?
                                  line4_s : conn_tmr_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_trigger_n_o <= 1'b1;
            dac_update_o <= 1'b0;
        end else begin
            timer_trigger_n_o <= next_timer_trigger_n;
            // converters load while the timer trigger is low
            dac_update_o <= delayed_update_i &&
                            !next_timer_trigger_n;
        end
    end

    // counter outputs are same-clock logic, so they are registered once without a synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line4_o <= 1'b0;
            line4_oe_o <= 1'b0;
            line2_o <= 1'b0;
            line2_oe_o <= 1'b0;
        end else begin
            line4_o <= counter5_output_i;
            line4_oe_o <= cmd2_upper[line4_drive_bit-8];
            line2_o <= counter2_output_i;
            line2_oe_o <= cmd2_upper[line2_drive_bit-8];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter1_gate_o <= 1'b0;
        end else if (cmd2_upper[line2_receive_bit-8]) begin
            counter1_gate_o <= line2_s;
        end else begin
            counter1_gate_o <= conn_gate_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_cfg_o <= '0;
        end else begin
            analog_cfg_o.out1_bipolar <=
                cmd2_upper[out1_bipolar_bit-8];
            analog_cfg_o.out0_bipolar <=
                cmd2_upper[out0_bipolar_bit-8];
            analog_cfg_o.out1_external_ref <=
                cmd2_upper[out1_ext_ref_bit-8];
            analog_cfg_o.out0_external_ref <=
                cmd2_upper[out0_ext_ref_bit-8];
        end
    end

    dma_channel_decode u_pri (
        .sel_i(cmd2_lower[pri_dma_lsb +: 3]),
        .enable_o(pri_en)
    );

    dma_channel_decode u_sec (
        .sel_i(cmd2_lower[sec_dma_lsb +: 3]),
        .enable_o(sec_en)
    );

    // outputs follow the lower byte even before software sets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_cfg_o <= '0;
        end else begin
            dma_cfg_o.demand_mode_dma_select <=
                cmd2_lower[demand_dma_bit];
            dma_cfg_o.primary_dma_ack_en <= pri_en;
            dma_cfg_o.secondary_dma_ack_en <= sec_en;
        end
    end
endmodule

// ===== hw/daq_cfg_pkg.sv
// package: register map, field positions and carrier types of the config bank
package daq_cfg_pkg;
    localparam int addr_w = 4;
    // byte addresses: register indices scaled to the 32-bit bus word
    localparam logic [3:0] cmd1_index = 4'h0;
    localparam logic [3:0] cmd2_index = 4'h2;
    localparam logic [3:0] start_index = 4'h3;
    localparam logic [addr_w-1:0] cmd1_addr = 4'h0;
    localparam logic [addr_w-1:0] cmd2_addr = 4'h8;
    localparam logic [addr_w-1:0] start_addr = 4'hc;
    localparam int acq_enable_bit = 8;
    localparam int bus_trigger_select_bit = 4;
    localparam int line4_receive_bit = 15;
    localparam int line4_drive_bit = 14;
    localparam int line2_receive_bit = 13;
    localparam int line2_drive_bit = 12;
    localparam int out1_bipolar_bit = 11;
    localparam int out0_bipolar_bit = 10;
    localparam int out1_ext_ref_bit = 9;
    localparam int out0_ext_ref_bit = 8;
    localparam int demand_dma_bit = 7;
    localparam int sec_dma_lsb = 3;
    localparam int pri_dma_lsb = 0;
    localparam logic [7:0] cmd2_upper_reset = 8'h00;
    localparam logic [1:0] cmd1_reset = 2'h0;
    localparam logic [2:0] dma_none_code = 3'h4;

    typedef struct packed {
        logic out1_bipolar;
        logic out0_bipolar;
        logic out1_external_ref;
        logic out0_external_ref;
    } analog_cfg_t;

    typedef struct packed {
        logic demand_mode_dma_select;
        logic [7:0] primary_dma_ack_en;
        logic [7:0] secondary_dma_ack_en;
    } dma_cfg_t;
endpackage

// ===== hw/dma_channel_decode.sv
// decodes a three-bit dma channel selector into one-hot channel enables, all clear for code four
`timescale 1ns/1ns
module dma_channel_decode (
    input wire logic [2:0] sel_i,
    output logic [7:0] enable_o
);
    import daq_cfg_pkg::*;
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_ch
            // code four selects nothing
            assign enable_o[ch] = (sel_i == 3'(ch)) &&
                                  (sel_i != dma_none_code);
        end
    endgenerate
endmodule

// ===== hw/sync_fall_detect.sv
// two-stage synchroniser with a one-cycle falling-edge pulse
`timescale 1ns/1ns
module sync_fall_detect (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o,
    output logic fall_o
);
    logic meta;
    logic level_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b1;
            level_o <= 1'b1;
            level_d <= 1'b1;
        end else begin
            meta <= async_i;
            level_o <= meta;
            level_d <= level_o;
        end
    end
    assign fall_o = level_d & ~level_o;
endmodule

// ===== tb/daq_cfg_assertions.sv
// checker: bus handshake, line drivers and config capture of the bank
`timescale 1ns/1ns
module daq_cfg_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [daq_cfg_pkg::addr_w-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic counter5_output_i,
    input wire logic counter2_output_i,
    input wire logic delayed_update_i,
    input wire logic line4_o,
    input wire logic line4_oe_o,
    input wire logic line2_o,
    input wire logic line2_oe_o,
    input wire logic timer_trigger_n_o,
    input wire logic dac_update_o,
    input wire logic acq_start_o,
    input wire daq_cfg_pkg::analog_cfg_t analog_cfg_o,
    input wire daq_cfg_pkg::dma_cfg_t dma_cfg_o
);
    import daq_cfg_pkg::*;
    logic cfg_wr;
    logic [3:0] exp_an;
    logic exp_dm;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign cfg_wr = wb_ack_o && wb_we_i && wb_adr_i == cmd2_addr;
    // data is still held by the master in the ack cycle
    always_ff @(posedge clk_i) begin
        if (cfg_wr && wb_sel_i[1])
            exp_an <= wb_dat_i[11:8];
        if (cfg_wr && wb_sel_i[0])
            exp_dm <= wb_dat_i[7];
    end
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("long ack");
    property p_rdata;
        wb_ack_o && !wb_we_i |-> wb_dat_o == 32'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data");
    property p_line4;
        line4_oe_o |-> line4_o == $past(counter5_output_i);
    endproperty
    a_line4: assert property (p_line4) else $error("line4 value");
    property p_line2;
        line2_oe_o |-> line2_o == $past(counter2_output_i);
    endproperty
    a_line2: assert property (p_line2) else $error("line2 value");
    property p_dac;
        dac_update_o == ($past(delayed_update_i) && !timer_trigger_n_o);
    endproperty
    a_dac: assert property (p_dac) else $error("dac update");
    property p_an;
        cfg_wr && wb_sel_i[1] |-> ##[1:3] analog_cfg_o == exp_an;
    endproperty
    a_an: assert property (p_an) else $error("analog cfg");
    property p_dm;
        cfg_wr && wb_sel_i[0] |-> ##[1:3]
            dma_cfg_o.demand_mode_dma_select == exp_dm;
    endproperty
    a_dm: assert property (p_dm) else $error("dma mode");
    // reset itself is the cause here, so it must not disable the check
    property p_rst;
        disable iff (1'b0) rst_i |=> timer_trigger_n_o && !acq_start_o
            && analog_cfg_o == 4'h0 && !line4_oe_o && !line2_oe_o;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind daq_trigger_routing_dac_dma_config daq_cfg_assertions u_chk (.*);

// ===== tb/trig_bus_agent.sv
// neighbour on the shared trigger bus, lines pulled up when released
`timescale 1ns/1ns
module trig_bus_agent (
    input wire logic d4_i,
    input wire logic d4_oe_i,
    input wire logic d2_i,
    input wire logic d2_oe_i,
    input wire logic a4_drv_i,
    input wire logic a4_val_i,
    input wire logic a2_drv_i,
    input wire logic a2_val_i,
    output logic l4_o,
    output logic l2_o
);
    assign l4_o = d4_oe_i ? d4_i : (a4_drv_i ? a4_val_i : 1'b1);
    assign l2_o = d2_oe_i ? d2_i : (a2_drv_i ? a2_val_i : 1'b1);
endmodule

// ===== tb/daq_trigger_routing_dac_dma_config_test.sv
// testbench: register writes, trigger routing and start sources
`timescale 1ns/1ns
module daq_trigger_routing_dac_dma_config_test;
    import daq_cfg_pkg::*;
    logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0;
    logic wb_we_i = '0, external_acq_trigger_n_i = '1, wb_ack_o;
    logic [addr_w-1:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic [3:0] wb_sel_i = '0;
    logic connector_timer_trigger_n_i = '1, connector_counter1_gate_i = '0;
    logic bus_start_trigger_n_i = '1, counter5_output_i = '0;
    logic counter2_output_i = '0, delayed_update_i = '0;
    logic a4d = '0, a4v = '1, a2d = '0, a2v = '1, line4_i, line2_i;
    logic line4_o, line4_oe_o, line2_o, line2_oe_o, counter1_gate_o;
    logic timer_trigger_n_o, dac_update_o, acq_start_o;
    analog_cfg_t analog_cfg_o;
    dma_cfg_t dma_cfg_o;
    int err_total = 0, checked = 0, starts = 0;
    daq_trigger_routing_dac_dma_config DUT (.*);
    trig_bus_agent u_bus (.d4_i(line4_o), .d4_oe_i(line4_oe_o),
        .d2_i(line2_o), .d2_oe_i(line2_oe_o), .a4_drv_i(a4d),
        .a4_val_i(a4v), .a2_drv_i(a2d), .a2_val_i(a2v),
        .l4_o(line4_i), .l2_o(line2_i));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (acq_start_o === 1'b1) starts++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= '1;
        wb_stb_i <= '1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        wb_sel_i <= 4'h3;
        for (i = 0; i < 8 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            end_sim();
        end
        wb_cyc_i <= '0;
        wb_stb_i <= '0;
        if (!w) chk(wb_dat_o, 32'h0);
    endtask
    function automatic logic [7:0] oh(input logic [2:0] k);
        return k == dma_none_code ? 8'h00 : 8'h01 << k;
    endfunction
    task automatic pulse(input logic bus);
        @(posedge clk_i);
        if (bus) bus_start_trigger_n_i <= '0;
        else external_acq_trigger_n_i <= '0;
        settle(6);
        @(posedge clk_i);
        bus_start_trigger_n_i <= '1;
        external_acq_trigger_n_i <= '1;
        settle(2);
    endtask
    task automatic t_cfg();
        logic [2:0] k;
        for (int c = 0; c < 8; c++) begin
            k = c[2:0];
            wb('1, cmd2_addr, {4'h0, k, ~k[2], k[0], 1'b0, ~k, k});
            settle(3);
            chk(analog_cfg_o, {k, ~k[2]});
            chk(dma_cfg_o.demand_mode_dma_select, k[0]);
            chk(dma_cfg_o.primary_dma_ack_en, oh(k));
            chk(dma_cfg_o.secondary_dma_ack_en, oh(~k));
        end
        wb('1, 4'h4, 16'hffff);
        wb('0, cmd2_addr, 16'h0);
        settle(3);
        chk(analog_cfg_o, 4'he);
        $display("test cfg done");
    endtask
    task automatic t_route();
        wb('1, cmd2_addr, 16'h8000);
        a4d <= '1;
        a4v <= '0;
        delayed_update_i <= '1;
        settle(5);
        chk(timer_trigger_n_o, 1'b0);
        chk(dac_update_o, 1'b1);
        wb('1, cmd2_addr, 16'h2000);
        a2d <= '1;
        a2v <= '0;
        connector_counter1_gate_i <= '1;
        settle(5);
        chk({counter1_gate_o, timer_trigger_n_o}, 2'h1);
        wb('1, cmd2_addr, 16'h5000);
        a2d <= '0;
        counter5_output_i <= '1;
        settle(5);
        chk({counter1_gate_o, line4_oe_o, line4_o, line2_oe_o, line2_o},
            5'h1e);
        $display("test route done");
    endtask
    task automatic t_start();
        wb('1, cmd1_addr, 16'h0000);
        wb('1, start_addr, 16'h0000);
        pulse('0);
        chk(starts, 0);
        wb('1, cmd1_addr, 16'h0100);
        wb('1, start_addr, 16'h0000);
        pulse('0);
        pulse('1);
        chk(starts, 2);
        wb('1, cmd1_addr, 16'h0110);
        wb('1, start_addr, 16'h0000);
        pulse('0);
        chk(starts, 2);
        pulse('1);
        chk(starts, 3);
        $display("test start done");
    endtask
    task automatic t_rst();
        wb('1, cmd2_addr, 16'hff2b);
        @(posedge clk_i);
        rst_i <= '1;
        settle(2);
        @(posedge clk_i);
        rst_i <= '0;
        settle(3);
        chk({analog_cfg_o, line4_oe_o, timer_trigger_n_o}, 6'h1);
        chk(dma_cfg_o.primary_dma_ack_en, 8'h08);
        chk(dma_cfg_o.secondary_dma_ack_en, 8'h20);
        $display("test reset done");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= '0;
        settle(1);
        chk({analog_cfg_o, timer_trigger_n_o}, 5'h1);
        t_cfg();
        t_route();
        t_start();
        t_rst();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        end_sim();
    end
endmodule
